// *** rtl/alem_pkg.sv ***
package alem_pkg;
  // operating modes of the element
  typedef enum logic [1:0] {ALEM_NORMAL, ALEM_EXTENDED, ALEM_ARITH, ALEM_SHARED} alem_mode_t;
  // normal-mode lookup splits
  typedef enum logic [2:0] {ALEM_N44, ALEM_N53, ALEM_N55, ALEM_N54, ALEM_N66, ALEM_N6LO, ALEM_N6HI} alem_sub_t;
  // register data sources
  typedef enum logic [1:0] {ALEM_SRC_FUNC, ALEM_SRC_PACK, ALEM_SRC_CHAIN} alem_src_t;

  // register byte offsets
  localparam logic [7:0] ALEM_OFF_CTRL = 8'h00;
  localparam logic [7:0] ALEM_OFF_LUT_LO_L = 8'h04;
  localparam logic [7:0] ALEM_OFF_LUT_LO_H = 8'h08;
  localparam logic [7:0] ALEM_OFF_LUT_HI_L = 8'h0c;
  localparam logic [7:0] ALEM_OFF_LUT_HI_H = 8'h10;
  localparam logic [7:0] ALEM_OFF_STATUS = 8'h14;

  // control field positions
  localparam int ALEM_F_MODE = 0;
  localparam int ALEM_F_SUB = 2;
  localparam int ALEM_F_SHAREB = 5;
  localparam int ALEM_F_COMBOUT = 6;
  localparam int ALEM_F_CSTART = 7;
  localparam int ALEM_F_CINIT = 8;
  localparam int ALEM_F_HBYP = 9;
  localparam int ALEM_F_LENA = 10;
  localparam int ALEM_F_CTAP = 11;
  localparam int ALEM_F_TSRC = 12;
  localparam int ALEM_F_BSRC = 14;
  localparam int ALEM_F_TPACK = 16;
  localparam int ALEM_F_BPACK = 18;
  localparam int ALEM_F_TPRE = 20;
  localparam int ALEM_F_BPRE = 21;

  // status bit positions
  localparam int ALEM_S_TOPQ = 0;
  localparam int ALEM_S_BOTQ = 1;
  localparam int ALEM_S_TOPC = 2;
  localparam int ALEM_S_BOTC = 3;
  localparam int ALEM_S_COUT = 4;
  localparam int ALEM_S_SOUT = 5;
  localparam int ALEM_S_CONF = 6;

  // reset values
  localparam logic [31:0] ALEM_CTRL_RST = 32'h0000_0000;
  localparam logic [63:0] ALEM_LUT_RST = 64'h0000_0000_0000_0000;
  localparam logic ALEM_FLOP_RST = 1'b0;

  // cluster geometry
  localparam int ALEM_CLUSTER_ELEMS = 8;
endpackage : alem_pkg

// *** rtl/alem_element.sv ***
// Notes on behaviour
// (RL1) one of four operating modes at a time
// (RL2) eleven inputs steered by selected mode
// (RL3) registers use cluster-wide control signals
// (RL4) normal: eight inputs, two or one six-input
// (RL5) independent 4+4 and 5+3 splits
// (RL6) 5+5 share a,b; 5+4 share a or b
// (RL7) dual six-input: shared a-d, same function
// (RL8) low selects to first_flop, high to second
// (RL9) async load data from e/f input; packing
// (RL10) six-input high frees e_lo/f_lo; f_hi conditional
// (RL11) extended: mux of two five-input functions
// (RL12) extended: no second_flop; eighth input packable
// (RL13) arithmetic: four 4-lookups, two full adders
// (RL14) carry in to lower, lower to upper, out
// (RL15) carry out alongside comb outputs, sum ignored
// (RL16) carry_result drives sync load for maximum; here sync load comes only from i_cl_sload, carry_o never feeds it
// (RL17) local enable from data input; sync cluster-wide
// (RL18) chain starts at element one or five
// (RL19) long chains continue into next cluster
// (RL20) half-bypassable chains skip the other half
// (RL21) shared mode: sum/carry lookups, shared chain
// (RL22) shared mode frees f_lo and f_hi
// (RL23) clear beats preset; device clear beats all
// (RL24) register chain feeds register input directly
// (RL25) mode and lookup contents static while clocked
//
// The implementer's own choices: the register offsets and the Wishbone register port.
module alem_element
  import alem_pkg::*;
#(
  parameter int ELEM_INDEX = 0,
  parameter int BYPASS_HALF = 0,
  parameter int CLUSTER_ELEMS = ALEM_CLUSTER_ELEMS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_lut_in_a,
  input wire logic i_lut_in_b,
  input wire logic i_lut_in_c,
  input wire logic i_lut_in_d,
  input wire logic i_lut_in_e_lo,
  input wire logic i_lut_in_f_lo,
  input wire logic i_lut_in_e_hi,
  input wire logic i_lut_in_f_hi,
  input wire logic i_carry_in,
  input wire logic i_share_in,
  input wire logic i_chain_in,
  input wire logic i_cl_ena,
  input wire logic i_cl_sclr,
  input wire logic i_cl_sload,
  input wire logic i_cl_aclr,
  input wire logic i_cl_aload,
  input wire logic i_device_wide_clear_n,
  output logic o_top_comb,
  output logic o_top_reg,
  output logic o_bot_comb,
  output logic o_bot_reg,
  output logic o_carry_out,
  output logic o_share_out,
  output logic o_chain_out
);

  // half boundary inside the cluster
  localparam int HALF = CLUSTER_ELEMS / 2;
  localparam logic MY_HALF = (ELEM_INDEX >= HALF);
  localparam logic START_OK = (ELEM_INDEX == 0) || (ELEM_INDEX == HALF);
  localparam logic BYP_OK = (MY_HALF == (BYPASS_HALF != 0));

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        r[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  // one-bit full adder, returns carry and sum
  function automatic logic [1:0] full_add(input logic x, input logic y, input logic z);
    return {(x & y) | (x & z) | (y & z), x ^ y ^ z};
  endfunction : full_add

  // pick one of the e/f inputs by 2-bit index
  function automatic logic pick_ef(input logic [3:0] ef, input logic [1:0] sel);
    return ef[sel];
  endfunction : pick_ef

  logic [31:0] ctrl_reg; // mode and routing configuration
  logic [63:0] lut_lo_reg; // low half lookup contents
  logic [63:0] lut_hi_reg; // high half lookup contents
  logic ack_reg; // bus acknowledge
  logic [31:0] rdat_reg; // registered read data
  logic top_q_reg; // first_flop
  logic bot_q_reg; // second_flop

  // decoded configuration fields
  alem_mode_t mode;
  logic [2:0] sub;
  logic [1:0] tsrc, bsrc, tpack, bpack;
  logic [3:0] ef; // {f_hi, e_hi, f_lo, e_lo}

  // combinational internals
  logic [5:0] idx_lo, idx_hi;
  logic [63:0] mask_hi;
  logic func_lo, func_hi;
  logic top_func, bot_func, carry_o, share_o;
  logic cin_eff;
  logic [3:0] lk;
  logic [1:0] add0, add1;
  logic top_d, bot_d, top_pack, bot_pack;
  logic ena_eff, bot_avail;
  logic [3:0] used;
  logic conflict;
  logic req;

  // (RL1) single mode field decode
  assign mode = alem_mode_t'(ctrl_reg[ALEM_F_MODE +: 2]);
  assign sub = ctrl_reg[ALEM_F_SUB +: 3];
  assign tsrc = ctrl_reg[ALEM_F_TSRC +: 2];
  assign bsrc = ctrl_reg[ALEM_F_BSRC +: 2];
  assign tpack = ctrl_reg[ALEM_F_TPACK +: 2];
  assign bpack = ctrl_reg[ALEM_F_BPACK +: 2];
  assign ef = {i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_f_lo, i_lut_in_e_lo};
  assign req = i_wb_cyc & i_wb_stb & ~ack_reg;

  // bus acknowledge, one cycle after the strobe, dropped next cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // configuration writes land at the acknowledged edge; rewriting while clocked is not supported
  // (RL25) static configuration store
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= ALEM_CTRL_RST;
      lut_lo_reg <= ALEM_LUT_RST;
      lut_hi_reg <= ALEM_LUT_RST;
    end else if (i_wb_cyc && i_wb_stb && ack_reg && i_wb_we) begin
      case (i_wb_adr)
        ALEM_OFF_CTRL: ctrl_reg <= wb_merge(ctrl_reg, i_wb_dat, i_wb_sel);
        ALEM_OFF_LUT_LO_L: lut_lo_reg[31:0] <= wb_merge(lut_lo_reg[31:0], i_wb_dat, i_wb_sel);
        ALEM_OFF_LUT_LO_H: lut_lo_reg[63:32] <= wb_merge(lut_lo_reg[63:32], i_wb_dat, i_wb_sel);
        ALEM_OFF_LUT_HI_L: lut_hi_reg[31:0] <= wb_merge(lut_hi_reg[31:0], i_wb_dat, i_wb_sel);
        ALEM_OFF_LUT_HI_H: lut_hi_reg[63:32] <= wb_merge(lut_hi_reg[63:32], i_wb_dat, i_wb_sel);
        // status and unmapped: write ignored
        default: ;
      endcase
    end
  end

  // read data, captured with the acknowledge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req) begin
      case (i_wb_adr)
        ALEM_OFF_CTRL: rdat_reg <= ctrl_reg;
        ALEM_OFF_LUT_LO_L: rdat_reg <= lut_lo_reg[31:0];
        ALEM_OFF_LUT_LO_H: rdat_reg <= lut_lo_reg[63:32];
        ALEM_OFF_LUT_HI_L: rdat_reg <= lut_hi_reg[31:0];
        ALEM_OFF_LUT_HI_H: rdat_reg <= lut_hi_reg[63:32];
        ALEM_OFF_STATUS: begin
          rdat_reg <= 32'h0000_0000;
          rdat_reg[ALEM_S_TOPQ] <= top_q_reg;
          rdat_reg[ALEM_S_BOTQ] <= bot_q_reg;
          rdat_reg[ALEM_S_TOPC] <= top_func;
          rdat_reg[ALEM_S_BOTC] <= bot_func;
          rdat_reg[ALEM_S_COUT] <= carry_o;
          rdat_reg[ALEM_S_SOUT] <= share_o;
          rdat_reg[ALEM_S_CONF] <= conflict;
        end
        // unmapped reads as zero
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // normal-mode input steering into the two lookup halves
  // (RL2) route local inputs per split
  always_comb begin
    idx_lo = 6'h00;
    idx_hi = 6'h00;
    mask_hi = lut_hi_reg;
    case (sub)
      // (RL5) two independent four-input functions
      ALEM_N44: begin
        idx_lo = {2'b00, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        idx_hi = {2'b00, i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_f_lo, i_lut_in_e_lo};
      end
      // (RL5) five plus independent three
      ALEM_N53: begin
        idx_lo = {1'b0, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        idx_hi = {3'b000, i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_f_lo};
      end
      // (RL6) two five-input sharing a and b
      ALEM_N55: begin
        idx_lo = {1'b0, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        idx_hi = {1'b0, i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_f_lo, i_lut_in_b, i_lut_in_a};
      end
      // (RL6) four-input sharing a or b
      ALEM_N54: begin
        idx_lo = {1'b0, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        idx_hi = {2'b00, i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_f_lo,
                  ctrl_reg[ALEM_F_SHAREB] ? i_lut_in_b : i_lut_in_a};
      end
      // (RL7) same function, unique e/f selects
      ALEM_N66: begin
        idx_lo = {i_lut_in_f_lo, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        idx_hi = {i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
        mask_hi = lut_lo_reg;
      end
      // (RL4) single six-input on the low half
      ALEM_N6LO: begin
        idx_lo = {i_lut_in_f_lo, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
      end
      // (RL4) single six-input on the high half
      ALEM_N6HI: begin
        idx_hi = {i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a};
      end
      default: ;
    endcase
    func_lo = lut_lo_reg[idx_lo];
    func_hi = mask_hi[idx_hi];
  end

  // mode datapath: lookups, adders and chains
  always_comb begin
    lk = 4'h0;
    add0 = 2'b00;
    add1 = 2'b00;
    top_func = 1'b0;
    bot_func = 1'b0;
    carry_o = 1'b0;
    share_o = 1'b0;
    // (RL18) chain start only at element one or five
    cin_eff = (ctrl_reg[ALEM_F_CSTART] && START_OK) ? ctrl_reg[ALEM_F_CINIT] : i_carry_in;
    case (mode)
      ALEM_NORMAL: begin
        // (RL8) low half to top, high half to bottom
        top_func = (sub == ALEM_N6HI) ? 1'b0 : func_lo;
        bot_func = (sub == ALEM_N6LO) ? 1'b0 : func_hi;
      end
      ALEM_EXTENDED: begin
        // (RL11) two five-input lookups muxed by f_lo
        lk[0] = lut_lo_reg[{1'b0, i_lut_in_e_lo, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        lk[1] = lut_hi_reg[{1'b0, i_lut_in_e_hi, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        top_func = i_lut_in_f_lo ? lk[1] : lk[0];
      end
      ALEM_ARITH: begin
        // (RL13) two pairs of four-input lookups sharing a, b
        lk[0] = lut_lo_reg[{2'b00, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        lk[1] = lut_lo_reg[{2'b01, i_lut_in_f_lo, i_lut_in_e_lo, i_lut_in_b, i_lut_in_a}];
        lk[2] = lut_hi_reg[{2'b00, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        lk[3] = lut_hi_reg[{2'b01, i_lut_in_f_hi, i_lut_in_e_hi, i_lut_in_b, i_lut_in_a}];
        // (RL14) carry ripples lower to upper adder
        add0 = full_add(lk[0], lk[1], cin_eff);
        add1 = full_add(lk[2], lk[3], add0[1]);
        carry_o = add1[1];
        // (RL15) comb lookups out with ALEM_F_COMBOUT set, sums ignored; otherwise the sums
        if (ctrl_reg[ALEM_F_COMBOUT]) begin
          top_func = lk[0];
          bot_func = lk[2];
        end else begin
          top_func = add0[0];
          bot_func = add1[0];
        end
        // (RL18) incoming carry i_carry_in tapped onto top routing
        if (ctrl_reg[ALEM_F_CTAP]) begin
          top_func = i_carry_in;
        end
      end
      ALEM_SHARED: begin
        // (RL21) sum and carry lookups of four inputs
        lk[0] = lut_lo_reg[{2'b00, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        lk[1] = lut_lo_reg[{2'b01, i_lut_in_d, i_lut_in_c, i_lut_in_b, i_lut_in_a}];
        lk[2] = lut_hi_reg[{2'b00, i_lut_in_e_hi, i_lut_in_e_lo, i_lut_in_b, i_lut_in_a}];
        lk[3] = lut_hi_reg[{2'b01, i_lut_in_e_hi, i_lut_in_e_lo, i_lut_in_b, i_lut_in_a}];
        // (RL21) shared chain into lower, local carry to upper
        add0 = full_add(lk[0], i_share_in, cin_eff);
        add1 = full_add(lk[2], lk[1], add0[1]);
        top_func = add0[0];
        bot_func = add1[0];
        carry_o = add1[1];
        share_o = lk[3];
      end
      default: ;
    endcase
    // (RL20) bypassed half passes both chains untouched
    if (ctrl_reg[ALEM_F_HBYP] && BYP_OK) begin
      carry_o = i_carry_in;
      share_o = i_share_in;
    end
  end

  // e/f inputs consumed by the function, for packing checks
  always_comb begin
    used = 4'hf;
    case (mode)
      ALEM_NORMAL: begin
        if (sub == ALEM_N6LO) begin
          used = 4'h3;
        end else if (sub == ALEM_N6HI) begin
          // (RL10) e_lo, f_lo free; f_hi only if unregistered
          used = (bsrc == ALEM_SRC_FUNC) ? 4'hc : 4'h4;
        end
      end
      // (RL12) eighth input f_hi free
      ALEM_EXTENDED: used = 4'h7;
      // (RL22) f_lo and f_hi free
      ALEM_SHARED: used = 4'h5;
      default: used = 4'hf;
    endcase
    conflict = 1'b0;
    if (tsrc == ALEM_SRC_PACK && used[tpack]) begin
      conflict = 1'b1;
    end
    if (bsrc == ALEM_SRC_PACK && used[bpack]) begin
      conflict = 1'b1;
    end
    if (tsrc == 2'b11 || bsrc == 2'b11) begin
      conflict = 1'b1;
    end
    if ((ctrl_reg[ALEM_F_CSTART] && !START_OK) || (ctrl_reg[ALEM_F_HBYP] && !BYP_OK)) begin
      conflict = 1'b1;
    end
    if (mode == ALEM_EXTENDED && bsrc != ALEM_SRC_FUNC) begin
      conflict = 1'b1;
    end
  end

  // register data and enable selection
  always_comb begin
    // (RL9) packed and async load data from e/f inputs
    top_pack = pick_ef(ef, tpack);
    bot_pack = pick_ef(ef, bpack);
    case (tsrc)
      ALEM_SRC_PACK: top_d = top_pack;
      // (RL24) chain input straight into first_flop
      ALEM_SRC_CHAIN: top_d = i_chain_in;
      default: top_d = top_func;
    endcase
    case (bsrc)
      ALEM_SRC_PACK: bot_d = bot_pack;
      // (RL24) first_flop shifts into second_flop
      ALEM_SRC_CHAIN: bot_d = top_q_reg;
      default: bot_d = bot_func;
    endcase
    // (RL17) local clock enable from f_lo in arithmetic
    ena_eff = i_cl_ena & ((mode == ALEM_ARITH && ctrl_reg[ALEM_F_LENA]) ? i_lut_in_f_lo : 1'b1);
    // (RL12) second_flop held in extended mode
    bot_avail = (mode != ALEM_EXTENDED);
  end

  // first_flop; controls are sampled on the element clock
  // (RL3) cluster-wide register controls
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      top_q_reg <= ALEM_FLOP_RST;
    // (RL23) device clear first, then clear over preset
    end else if (!i_device_wide_clear_n || i_cl_aclr) begin
      top_q_reg <= 1'b0;
    end else if (i_cl_aload) begin
      top_q_reg <= ctrl_reg[ALEM_F_TPRE] ? 1'b1 : top_pack;
    end else if (ena_eff) begin
      // (RL17) cluster-wide sync clear and load
      if (i_cl_sclr) begin
        top_q_reg <= 1'b0;
      // (RL16) sync load takes the y operand
      end else if (i_cl_sload) begin
        top_q_reg <= i_lut_in_c;
      end else begin
        top_q_reg <= top_d;
      end
    end
  end

  // second_flop
  // (RL3) cluster-wide register controls
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bot_q_reg <= ALEM_FLOP_RST;
    // (RL23) device clear first, then clear over preset
    end else if (!i_device_wide_clear_n || i_cl_aclr) begin
      bot_q_reg <= 1'b0;
    end else if (i_cl_aload && bot_avail) begin
      bot_q_reg <= ctrl_reg[ALEM_F_BPRE] ? 1'b1 : bot_pack;
    end else if (ena_eff && bot_avail) begin
      if (i_cl_sclr) begin
        bot_q_reg <= 1'b0;
      // (RL16) sync load takes the y operand
      end else if (i_cl_sload) begin
        bot_q_reg <= i_lut_in_d;
      end else begin
        bot_q_reg <= bot_d;
      end
    end
  end

  // outputs; comb outputs are the unregistered functions
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  assign o_top_comb = top_func;
  assign o_bot_comb = bot_func;
  assign o_top_reg = top_q_reg;
  assign o_bot_reg = bot_q_reg;
  // (RL19) chains leave toward the next element or cluster
  assign o_carry_out = carry_o;
  assign o_share_out = share_o;
  assign o_chain_out = bot_q_reg;

endmodule : alem_element

// *** verif/alem_chk.sv ***
module alem_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_lut_in_c,
  input wire logic i_cl_ena,
  input wire logic i_cl_sclr,
  input wire logic i_cl_sload,
  input wire logic i_cl_aclr,
  input wire logic i_cl_aload,
  input wire logic i_device_wide_clear_n,
  input wire logic o_top_reg,
  input wire logic o_bot_reg,
  input wire logic o_chain_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // no async control active, so sync paths decide
  logic quiet;
  assign quiet = !i_cl_aclr && !i_cl_aload && i_device_wide_clear_n;

  a_ack_follows: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("ack missing after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_devclr_wins: assert property (!i_device_wide_clear_n |=> !o_top_reg && !o_bot_reg)
    else $error("device clear ignored");
  a_aclr_wins: assert property (i_cl_aclr |=> !o_top_reg && !o_bot_reg)
    else $error("clear lost to preset");
  a_sclr_flops: assert property ((i_cl_ena && i_cl_sclr && quiet) |=> !o_top_reg && !o_bot_reg)
    else $error("sync clear ignored");
  a_sload_top: assert property ((i_cl_ena && i_cl_sload && !i_cl_sclr && quiet)
    |=> o_top_reg == $past(i_lut_in_c))
    else $error("sync load value wrong");
  a_hold_noena: assert property ((!i_cl_ena && quiet) |=> $stable(o_top_reg) && $stable(o_bot_reg))
    else $error("flop moved without enable");
  a_chain_tap: assert property (o_chain_out == o_bot_reg)
    else $error("chain out differs from second flop");
endmodule : alem_chk

bind alem_element alem_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_lut_in_c(i_lut_in_c), .i_cl_ena(i_cl_ena), .i_cl_sclr(i_cl_sclr),
  .i_cl_sload(i_cl_sload), .i_cl_aclr(i_cl_aclr), .i_cl_aload(i_cl_aload),
  .i_device_wide_clear_n(i_device_wide_clear_n), .o_top_reg(o_top_reg), .o_bot_reg(o_bot_reg),
  .o_chain_out(o_chain_out));

// *** verif/alem_nbr.sv ***
// previous element in the cluster, seen from this one
module alem_nbr (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_shift,
  input wire logic i_carry,
  output logic o_chain,
  output logic o_carry
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_chain <= 1'b0;
    end else begin
      o_chain <= i_shift;
    end
  end
  assign o_carry = i_carry;
endmodule : alem_nbr

// *** verif/tb_alem_element.sv ***
module tb_alem_element
  import alem_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cin = 1'b0, shin = 1'b0, shr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q_dat;
  // {f_hi,e_hi,f_lo,e_lo,d,c,b,a}
  logic [7:0] din = 8'h00;
  // {ena,sclr,sload,aclr,aload,clear_n}
  logic [5:0] ctl = 6'b000001;
  logic ack, top_c, top_r, bot_c, bot_r, cout, sout, chout, ch_in, c_in;
  int err_total = 0, checks = 0, cyc_cnt = 0;

  always #5 clk = ~clk;

  alem_nbr nbr_u (.i_clk(clk), .i_rst(rst), .i_shift(shin), .i_carry(cin), .o_chain(ch_in), .o_carry(c_in));
  alem_element dut_u (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(q_dat), .o_wb_ack(ack), .i_lut_in_a(din[0]),
    .i_lut_in_b(din[1]), .i_lut_in_c(din[2]), .i_lut_in_d(din[3]), .i_lut_in_e_lo(din[4]),
    .i_lut_in_f_lo(din[5]), .i_lut_in_e_hi(din[6]), .i_lut_in_f_hi(din[7]), .i_carry_in(c_in),
    .i_share_in(shr), .i_chain_in(ch_in), .i_cl_ena(ctl[5]), .i_cl_sclr(ctl[4]), .i_cl_sload(ctl[3]),
    .i_cl_aclr(ctl[2]), .i_cl_aload(ctl[1]), .i_device_wide_clear_n(ctl[0]), .o_top_comb(top_c),
    .o_top_reg(top_r), .o_bot_comb(bot_c), .o_bot_reg(bot_r), .o_carry_out(cout), .o_share_out(sout),
    .o_chain_out(chout));

  task automatic end_of_test();
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // classic cycle; a dead slave is caught by the hang guard below
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = q_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic luts(input logic [31:0] ll, input logic [31:0] lh, input logic [31:0] hl, input logic [31:0] hh);
    wr(ALEM_OFF_LUT_LO_L, ll);
    wr(ALEM_OFF_LUT_LO_H, lh);
    wr(ALEM_OFF_LUT_HI_L, hl);
    wr(ALEM_OFF_LUT_HI_H, hh);
  endtask : luts

  task automatic drv(input logic [7:0] d);
    @(posedge clk);
    din <= d;
    @(negedge clk);
  endtask : drv

  // controls held over one capture edge, then both flops compared
  task automatic step(input logic [5:0] c, input logic [7:0] d, input logic [1:0] e);
    @(posedge clk);
    ctl <= c;
    din <= d;
    @(posedge clk);
    @(negedge clk);
    chk({bot_r, top_r}, e);
  endtask : step

  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] q;
    logic [7:0] d8;
    logic et, eb, c0;
    logic [2:0] sub_v [4];
    logic [31:0] lol [4], loh [4], hil [4];
    logic [7:0] pat;
    sub_v = '{3'h0, 3'h1, 3'h4, 3'h2};
    lol = '{32'h0000_8000, 32'h8000_0000, 32'h0000_0000, 32'h8000_0000};
    loh = '{32'h0, 32'h0, 32'h8000_0000, 32'h0};
    hil = '{32'h0000_0001, 32'h0000_0001, 32'h0, 32'h0000_0001};
    pat = 8'b0100_1101;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ALEM_OFF_CTRL, 32'h0, q);
    chk(q, ALEM_CTRL_RST);
    wb(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    wr(ALEM_OFF_STATUS, 32'hffff_ffff);
    wb(1'b0, ALEM_OFF_STATUS, 32'h0, q);
    chk(q[5:0], 6'h00);
    wr(ALEM_OFF_LUT_HI_H, 32'h1234_abcd);
    wb(1'b0, ALEM_OFF_LUT_HI_H, 32'h0, q);
    chk(q, 32'h1234_abcd);
    // normal splits 4+4, 5+3, dual six and 5+5, every input pattern
    for (int k = 0; k < 4; k++) begin
      wr(ALEM_OFF_CTRL, {27'h0, sub_v[k], 2'b00});
      luts(lol[k], loh[k], hil[k], 32'h0);
      ctl <= 6'b100001;
      for (int i = 0; i < 256; i++) begin
        d8 = i[7:0];
        drv(d8);
        et = (k == 0) ? &d8[3:0] : (k == 2) ? &d8[5:0] : &d8[4:0];
        eb = (k == 0) ? (d8[7:4] == 4'h0) : (k == 1) ? (d8[7:5] == 3'h0) : (k == 2) ? &{d8[7:6], d8[3:0]} :
          ({d8[7:5], d8[1:0]} == 5'h00);
        chk(top_c, et);
        chk(bot_c, eb);
        @(negedge clk);
        chk({bot_r, top_r}, {eb, et});
      end
    end
    // arithmetic: lk0=a, lk1=b on both adders
    wr(ALEM_OFF_CTRL, 32'h0000_0002);
    luts(32'hcccc_aaaa, 32'h0, 32'hcccc_aaaa, 32'h0);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      cin <= j[2];
      din <= {6'h00, j[1:0]};
      @(negedge clk);
      c0 = (j[0] & j[1]) | (j[0] & j[2]) | (j[1] & j[2]);
      chk(cout, (j[0] & j[1]) | (j[0] & c0) | (j[1] & c0));
      @(negedge clk);
      chk(top_r, j[0] ^ j[1] ^ j[2]);
    end
    wr(ALEM_OFF_CTRL, 32'h0000_0042);
    drv(8'h01);
    chk(top_c, 1'b1);
    drv(8'h02);
    chk({cout, top_c}, 2'b10);
    // chain start takes the init carry, bypass passes carry in
    cin <= 1'b0;
    wr(ALEM_OFF_CTRL, 32'h0000_0182);
    drv(8'h00);
    chk(top_c, 1'b1);
    cin <= 1'b1;
    wr(ALEM_OFF_CTRL, 32'h0000_0202);
    drv(8'h00);
    chk(cout, 1'b1);
    // flop controls: top=a, bottom=e_lo, top preset on load
    wr(ALEM_OFF_CTRL, 32'h0010_0000);
    step(6'b100001, 8'h01, 2'b01);
    step(6'b100101, 8'h01, 2'b00);
    step(6'b000011, 8'h00, 2'b01);
    step(6'b000111, 8'h00, 2'b00);
    step(6'b000010, 8'h01, 2'b00);
    step(6'b101001, 8'h09, 2'b10);
    step(6'b101001, 8'h04, 2'b01);
    step(6'b111001, 8'h0c, 2'b00);
    step(6'b000001, 8'h01, 2'b00);
    // shift through upstream flop, first_flop, second_flop
    wr(ALEM_OFF_CTRL, 32'h0000_a000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      ctl <= 6'b100001;
      shin <= pat[i];
      @(negedge clk);
      if (i >= 3) chk(chout, pat[i-3]);
    end
    // extended: top = !f_lo, second_flop frozen
    wr(ALEM_OFF_CTRL, 32'h0020_0001);
    luts(32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h0);
    drv(8'h00);
    chk({bot_c, top_c}, 2'b01);
    drv(8'h30);
    chk({bot_c, top_c}, 2'b00);
    step(6'b000010, 8'h00, 2'b00);
    step(6'b101001, 8'h08, 2'b00);
    step(6'b100001, 8'h00, 2'b01);
    step(6'b000011, 8'h00, 2'b00);
    // shared: share chain carries lk3
    wr(ALEM_OFF_CTRL, 32'h0000_0003);
    wr(ALEM_OFF_LUT_HI_L, 32'hffff_0000);
    drv(8'h00);
    chk(sout, 1'b1);
    wr(ALEM_OFF_LUT_HI_L, 32'h0000_ffff);
    drv(8'h00);
    chk(sout, 1'b0);
    chk({cout, bot_c, top_c}, 3'b110);
    // shared chain bit enters the lower adder
    @(posedge clk);
    shr <= 1'b1;
    @(negedge clk);
    chk({cout, bot_c, top_c}, 3'b111);
    end_of_test();
  end
endmodule : tb_alem_element
